// ### hdl/scpa_pkg.sv
// Shared constants and types for the serial configuration PROM access block.
// Assumes a word width that is a power of two and a config clock made by the partner.
package scpa_pkg;

    localparam int          SCPA_WORD_W      = 32;
    localparam int          SCPA_DEPTH       = 4096;
    localparam int          SCPA_SYNC_STAGES = 2;
    localparam logic [31:0] SCPA_POL_LOW     = 32'h0000_0000;
    localparam logic [31:0] SCPA_POL_ERASED  = 32'hffff_ffff;

    // Gray-coded along read -> arm -> arm -> program
    typedef enum logic [1:0] {
        SCPA_READ = 2'b00,
        SCPA_ARM1 = 2'b01,
        SCPA_ARM2 = 2'b11,
        SCPA_PROG = 2'b10
    } scpa_mode_t;

endpackage : scpa_pkg

// ### hdl/scpa_sync.sv
// Level synchroniser, also used as a reset synchroniser.
// Assumes each bit is an independent level; no multi-bit coherence is given.
`timescale 1ns/1ps
module scpa_sync
    import scpa_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage [SCPA_SYNC_STAGES];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SCPA_SYNC_STAGES; i++) begin
                stage[i] <= RST_VAL;
            end
        end else begin
            stage[0] <= d;
            for (int i = 1; i < SCPA_SYNC_STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign q = stage[SCPA_SYNC_STAGES-1];

endmodule : scpa_sync

// ### hdl/scpa_mem.sv
// Storage array of the PROM, one write port and a registered read port.
// Assumes the caller keeps addresses inside the array.
`timescale 1ns/1ps
module scpa_mem
    import scpa_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 4096,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    logic [W-1:0] array [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            array[wr_addr] <= wr_data;
        end
        rd_data <= array[rd_addr];
    end

endmodule : scpa_mem

// ### hdl/scpa_top.sv
// Serial configuration PROM: read sequencer, cascade, programming mode, pin drivers.
// Assumes the partner drives config_clock and the control pins synchronously to it;
// pin drivers run on clk and see link state through two-flop synchronisers.
`timescale 1ns/1ps
module scpa_top
    import scpa_pkg::*;
#(
    parameter int WORD_W = SCPA_WORD_W,
    parameter int DEPTH  = SCPA_DEPTH
) (
    // System clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Link clock from the configuring device
    input  wire logic config_clock,
    // Control pins
    input  wire logic chip_select_n,
    input  wire logic reset_oe,
    input  wire logic high_program_voltage,
    input  wire logic program_access_voltage,
    // Data pin
    input  wire logic data_in,
    output logic      data_out,
    output logic      data_oe,
    // Chain output
    output logic      cascade_enable_out
);

    localparam int BW  = $clog2(WORD_W);
    localparam int AW  = $clog2(DEPTH + 1);
    localparam int MAW = $clog2(DEPTH);
    localparam int CW  = AW + BW;
    localparam logic [AW-1:0] LAST_WORD = AW'(DEPTH);

    // ************************************************************
    // Link-domain reset
    // ************************************************************
    logic rst_link;

    scpa_sync #(.W(1), .RST_VAL(1'b1)) u_link_rst (
        .clk (config_clock),
        .rst (rst),
        .d   (1'b0),
        .q   (rst_link)
    );

    // ************************************************************
    // Link domain: counters, modes, storage
    // ************************************************************
    scpa_mode_t        mode,     next_mode;
    logic [CW-1:0]     cnt,      next_cnt;
    logic              done,     next_done;
    logic              bit_q,    next_bit;
    logic [WORD_W-1:0] wr_word,  next_wr_word;
    logic [WORD_W-1:0] pol_word, next_pol_word;
    logic              vh_q;
    logic              mem_we;
    logic [WORD_W-1:0] mem_rd;
    logic [WORD_W-1:0] rd_word;
    logic [AW-1:0]     word_idx;
    logic [BW-1:0]     bit_idx;
    logic [AW-1:0]     next_word_idx;
    logic              at_end;
    logic              pol_low;
    logic              reset_lvl;
    logic              rd_is_pol;
    logic              pgm_strobe;

    assign word_idx      = cnt[CW-1:BW];
    assign bit_idx       = cnt[BW-1:0];
    assign next_word_idx = next_cnt[CW-1:BW];
    assign at_end        = (word_idx == LAST_WORD);
    assign pol_low       = (pol_word == SCPA_POL_LOW[WORD_W-1:0]);
    assign reset_lvl     = pol_low ? ~reset_oe : reset_oe;
    assign rd_word       = rd_is_pol ? pol_word : mem_rd;
    assign pgm_strobe    = high_program_voltage & ~vh_q;

    always_comb begin
        next_mode     = mode;
        next_cnt      = cnt;
        next_done     = done;
        next_bit      = bit_q;
        next_wr_word  = wr_word;
        next_pol_word = pol_word;
        mem_we        = 1'b0;
        case (mode)
            SCPA_READ: begin
                if (reset_lvl) begin
                    next_cnt  = '0;
                    next_done = 1'b0;
                end else if (!chip_select_n) begin
                    if (at_end) begin
                        next_done = 1'b1;
                    end else begin
                        next_bit = rd_word[bit_idx];
                        next_cnt = cnt + CW'(1);
                    end
                end
                if (chip_select_n && reset_oe && high_program_voltage) begin
                    next_mode = SCPA_ARM1;
                end
            end
            SCPA_ARM1: begin
                if (chip_select_n && reset_oe && high_program_voltage) begin
                    next_mode = SCPA_ARM2;
                end else begin
                    next_mode = SCPA_READ;
                end
            end
            SCPA_ARM2: begin
                if (!(chip_select_n && reset_oe)) begin
                    next_mode = SCPA_READ;
                end else if (program_access_voltage && !high_program_voltage) begin
                    next_mode = SCPA_PROG;
                    next_cnt  = '0;
                    next_done = 1'b0;
                end
            end
            SCPA_PROG: begin
                // Pin polarity is fixed here; reset_lvl is not consulted
                if (!chip_select_n && !reset_oe) begin
                    next_mode = SCPA_READ;
                    next_cnt  = '0;
                end else if (pgm_strobe) begin
                    // A strobe edge only burns the word, nothing shifts
                    if (at_end) begin
                        next_pol_word = wr_word;
                    end else begin
                        mem_we = 1'b1;
                    end
                end else if (chip_select_n && reset_oe) begin
                    next_wr_word[bit_idx] = data_in;
                    next_cnt = {word_idx, bit_idx + BW'(1)};
                end else if (!chip_select_n && reset_oe) begin
                    next_bit = rd_word[bit_idx];
                    next_cnt = {word_idx, bit_idx + BW'(1)};
                end else if (!at_end) begin
                    next_cnt = {word_idx + AW'(1), BW'(0)};
                end
            end
            default: begin
                next_mode = SCPA_READ;
            end
        endcase
    end

    always_ff @(posedge config_clock or posedge rst_link) begin
        if (rst_link) begin
            mode      <= SCPA_READ;
            cnt       <= '0;
            done      <= 1'b0;
            bit_q     <= 1'b0;
            wr_word   <= '0;
            pol_word  <= SCPA_POL_ERASED[WORD_W-1:0];
            vh_q      <= 1'b0;
            rd_is_pol <= 1'b0;
        end else begin
            mode      <= next_mode;
            cnt       <= next_cnt;
            done      <= next_done;
            bit_q     <= next_bit;
            wr_word   <= next_wr_word;
            pol_word  <= next_pol_word;
            vh_q      <= high_program_voltage;
            rd_is_pol <= (next_word_idx == LAST_WORD);
        end
    end

    // Read address follows the next counter so the word is ready on arrival
    scpa_mem #(.W(WORD_W), .DEPTH(DEPTH)) u_mem (
        .clk     (config_clock),
        .wr_en   (mem_we),
        .wr_addr (word_idx[MAW-1:0]),
        .wr_data (wr_word),
        .rd_addr (next_word_idx[MAW-1:0]),
        .rd_data (mem_rd)
    );

    // ************************************************************
    // Crossing into the system clock
    // ************************************************************
    logic [5:0] sync_q;
    logic       ce_n_s;
    logic       roe_s;
    logic       done_s;
    logic       prog_s;
    logic       pol_low_s;
    logic       bit_s;

    scpa_sync #(.W(6), .RST_VAL(6'h20)) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .d   ({chip_select_n, reset_oe, done, mode == SCPA_PROG, pol_low, bit_q}),
        .q   (sync_q)
    );

    assign {ce_n_s, roe_s, done_s, prog_s, pol_low_s, bit_s} = sync_q;

    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic oe_act_s;
    logic next_data_out;
    logic next_data_oe;
    logic next_cascade;

    // Polarity swap is bypassed in programming mode
    assign oe_act_s = (prog_s || pol_low_s) ? roe_s : ~roe_s;

    always_comb begin
        next_data_out = bit_s;
        next_data_oe  = ~ce_n_s & oe_act_s & (prog_s | ~done_s);
        if (prog_s) begin
            next_cascade = ~pol_low_s;
        end else if (done_s) begin
            next_cascade = ce_n_s;
        end else begin
            next_cascade = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out           <= 1'b0;
            data_oe            <= 1'b0;
            cascade_enable_out <= 1'b1;
        end else begin
            data_out           <= next_data_out;
            data_oe            <= next_data_oe;
            cascade_enable_out <= next_cascade;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    cnt_clear_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_READ && reset_lvl) |=> (cnt == '0 && !done))
        else $error("counters not cleared at reset level");

    cnt_step_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_READ && !reset_lvl && !chip_select_n && !at_end)
        |=> (cnt == $past(cnt) + CW'(1)))
        else $error("read counter did not advance");

    standby_freeze_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_READ && !reset_lvl && chip_select_n) |=> $stable(cnt))
        else $error("counter moved in standby");

    done_set_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_READ && !reset_lvl && !chip_select_n && at_end) |=> done)
        else $error("end of memory not flagged");

    standby_float_a : assert property (@(posedge clk) disable iff (rst)
        ce_n_s |=> !data_oe)
        else $error("data driven in standby");

    drive_gate_a : assert property (@(posedge clk) disable iff (rst)
        data_oe |-> $past(!ce_n_s && oe_act_s))
        else $error("data driven without select and enable");

    release_a : assert property (@(posedge clk) disable iff (rst)
        (done_s && !prog_s) |=> (!data_oe && cascade_enable_out == $past(ce_n_s)))
        else $error("data not released with cascade");

    cascade_idle_a : assert property (@(posedge clk) disable iff (rst)
        (!done_s && !prog_s) |=> cascade_enable_out)
        else $error("cascade low before end of memory");

    prog_exit_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_PROG && !chip_select_n && !reset_oe) |=> (mode == SCPA_READ))
        else $error("programming mode not left");

    prog_step_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_PROG && chip_select_n && !reset_oe && !pgm_strobe && !at_end)
        |=> (word_idx == $past(word_idx) + AW'(1) && bit_idx == '0))
        else $error("word counter did not step");

    pol_report_a : assert property (@(posedge clk) disable iff (rst)
        prog_s [*2] |-> ##1 (cascade_enable_out == !$past(pol_low_s)))
        else $error("polarity not shown on cascade");

    prog_entry_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_ARM2 && chip_select_n && reset_oe
         && program_access_voltage && !high_program_voltage)
        |=> (mode == SCPA_PROG && cnt == '0))
        else $error("programming mode not entered");

    prog_shift_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_PROG && chip_select_n && reset_oe && !pgm_strobe)
        |=> (bit_idx == $past(bit_idx) + BW'(1) && wr_word[$past(bit_idx)] == $past(data_in)))
        else $error("data bit not shifted in");

    pol_write_a : assert property (@(posedge config_clock) disable iff (rst_link)
        (mode == SCPA_PROG && pgm_strobe && at_end && !(!chip_select_n && !reset_oe))
        |=> (pol_word == $past(wr_word)))
        else $error("polarity word not stored");

    cover_full_read : cover property (@(posedge config_clock) disable iff (rst_link)
        $rose(done));
    cover_prog_entry : cover property (@(posedge config_clock) disable iff (rst_link)
        mode == SCPA_ARM2 ##1 mode == SCPA_PROG);
    cover_cascade : cover property (@(posedge clk) disable iff (rst)
        $fell(cascade_enable_out) && !prog_s);
    cover_pol_low : cover property (@(posedge config_clock) disable iff (rst_link)
        $rose(pol_low));

endmodule : scpa_top

// ### verification/scpa_host_model.sv
// Partner model: configuration controller on the far side of the PROM pins.
// Assumes the bench calls its tasks one at a time; pins change only between link pulses.
`timescale 1ns/1ps
module scpa_host_model
    import scpa_pkg::*;
(
    // Timing reference
    input  wire logic clk,
    // Device data pin
    input  wire logic data_out,
    input  wire logic data_oe,
    // Link clock and control pins
    output logic      config_clock,
    output logic      chip_select_n,
    output logic      reset_oe,
    output logic      high_program_voltage,
    output logic      program_access_voltage,
    // Resolved data line
    output logic      data_in
);
    logic host_drive;
    logic host_bit;
    logic filler;
    logic prog_clk;

    // ****************************************
    // Pin levels at time zero
    // ****************************************
    initial begin
        config_clock           = 1'b0;
        chip_select_n          = 1'b1;
        reset_oe               = 1'b0;
        high_program_voltage   = 1'b0;
        program_access_voltage = 1'b0;
        host_drive             = 1'b0;
        host_bit               = 1'b0;
        filler                 = 1'b0;
        prog_clk               = 1'b0;
    end

    // Undriven line toggles so a stale value never passes for a match
    always @(posedge clk) begin
        filler <= ~filler;
    end

    assign data_in = data_oe ? data_out : (host_drive ? host_bit : filler);

    // ****************************************
    // One link clock pulse, clock stands low outside it, or high while programming
    // ****************************************
    task automatic pulse();
        if (prog_clk) begin
            // Programming: clock idles high so chip select only moves while it is high
            #3 config_clock = 1'b0;
            #3 config_clock = 1'b1;
        end else begin
            #3 config_clock = 1'b1;
            #3 config_clock = 1'b0;
        end
    endtask : pulse

    // Set pins, give one rising edge, let pin drivers settle, then sample the line
    task automatic step(input logic cs_n, input logic oe, input logic hv, input logic av,
                        input logic drv, input logic din, output logic seen);
        @(posedge clk);
        #2;
        chip_select_n          = cs_n;
        reset_oe               = oe;
        high_program_voltage   = hv;
        program_access_voltage = av;
        host_drive             = drv;
        host_bit               = din;
        pulse();
        if (prog_clk && !cs_n && !oe) begin
            // Exit edge given; clock returns to its low idle level
            prog_clk = 1'b0;
            #3 config_clock = 1'b0;
        end
        // Ten cycles keep the clock at its idle level over 200 ns before the next pin change
        repeat (10) @(posedge clk);
        #1 seen = data_in;
    endtask : step

    // Select and enable high, high level for two edges, access level for one
    task automatic enter_prog();
        logic s;
        step(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, s);
        step(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, s);
        prog_clk = 1'b1;
        step(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, s);
    endtask : enter_prog

endmodule : scpa_host_model

// ### verification/scpa_top_tb_top.sv
// Self-checking bench: programs the PROM, reads it back through the cascade logic.
// Assumes a shortened array (four words) and a short programming strobe.
`timescale 1ns/1ps
module scpa_top_tb_top
    import scpa_pkg::*;
;
    localparam int WW  = 32;
    localparam int DEP = 4;
    localparam int NB  = WW * DEP;

    logic        clk;
    logic        rst;
    logic        config_clock;
    logic        chip_select_n;
    logic        reset_oe;
    logic        hv;
    logic        av;
    logic        data_in;
    logic        data_out;
    logic        data_oe;
    logic        cascade_enable_out;
    logic        seen;
    logic        acc_lvl;
    logic [31:0] mem [DEP];
    int          fail_count;
    int          checks;

    scpa_top #(.WORD_W(WW), .DEPTH(DEP)) i_scpa_top (
        .clk(clk), .rst(rst), .config_clock(config_clock),
        .chip_select_n(chip_select_n), .reset_oe(reset_oe),
        .high_program_voltage(hv), .program_access_voltage(av),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .cascade_enable_out(cascade_enable_out)
    );

    scpa_host_model i_scpa_host_model (
        .clk(clk), .data_out(data_out), .data_oe(data_oe),
        .config_clock(config_clock), .chip_select_n(chip_select_n),
        .reset_oe(reset_oe), .high_program_voltage(hv),
        .program_access_voltage(av), .data_in(data_in)
    );

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic check1(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check1

    task automatic summarize();
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task automatic st(input logic cs_n, input logic oe, input logic drv, input logic din);
        i_scpa_host_model.step(cs_n, oe, 1'b0, acc_lvl, drv, din, seen);
    endtask : st

    // Enabled read edge; expected bit comes from the bench's own array copy
    task automatic rd(input logic oe, input int idx);
        st(1'b0, oe, 1'b0, 1'b0);
        check1("data_oe", 1'b1, data_oe);
        check1("data", mem[idx / WW][idx % WW], seen);
        check1("cascade", 1'b1, cascade_enable_out);
    endtask : rd

    // Shift one word in bit 0 first, then strobe it with a rising high level
    task automatic shift_word(input logic [31:0] w);
        for (int i = 0; i < WW; i++) begin
            st(1'b1, 1'b1, 1'b1, w[i]);
        end
        // Strobe spans one step; the design acts only on its rising edge
        i_scpa_host_model.step(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, seen);
    endtask : shift_word

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h43f39947));
        fail_count = 0;
        checks     = 0;
        acc_lvl    = 1'b0;
        rst        = 1'b1;
        // Link reset needs a link edge while rst is high
        i_scpa_host_model.pulse();
        repeat (4) @(posedge clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 3; i++) st(1'b1, 1'b0, 1'b0, 1'b0);
        check1("cascade", 1'b1, cascade_enable_out);
        check1("data_oe", 1'b0, data_oe);
        for (int w = 0; w < DEP; w++) mem[w] = $urandom;
        i_scpa_host_model.enter_prog();
        acc_lvl = 1'b1;
        check1("cascade", 1'b1, cascade_enable_out);
        for (int w = 0; w < DEP; w++) begin
            shift_word(mem[w]);
            st(1'b1, 1'b0, 1'b0, 1'b0);
        end
        st(1'b0, 1'b0, 1'b0, 1'b0);
        acc_lvl = 1'b0;
        check1("data_oe", 1'b1, data_oe);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        check1("data_oe", 1'b0, data_oe);
        for (int i = 0; i < NB; i++) begin
            if (i == 40) begin
                // Standby in mid-read must not lose the position
                for (int k = 0; k < 3; k++) st(1'b1, 1'b0, 1'b0, 1'b0);
                check1("data_oe", 1'b0, data_oe);
            end
            rd(1'b0, i);
        end
        st(1'b0, 1'b0, 1'b0, 1'b0);
        check1("data_oe", 1'b0, data_oe);
        check1("cascade", 1'b0, cascade_enable_out);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        check1("cascade", 1'b0, cascade_enable_out);
        check1("data_oe", 1'b0, data_oe);
        st(1'b1, 1'b0, 1'b0, 1'b0);
        check1("cascade", 1'b1, cascade_enable_out);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        check1("cascade", 1'b0, cascade_enable_out);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        check1("cascade", 1'b1, cascade_enable_out);
        for (int i = 0; i < 8; i++) rd(1'b0, i);
        // Program the overflow word to zeros: reset turns active low
        i_scpa_host_model.enter_prog();
        acc_lvl = 1'b1;
        for (int w = 0; w < DEP; w++) st(1'b1, 1'b0, 1'b0, 1'b0);
        shift_word(32'h0000_0000);
        st(1'b1, 1'b1, 1'b0, 1'b0);
        check1("cascade", 1'b0, cascade_enable_out);
        for (int i = 0; i < 2; i++) begin
            st(1'b0, 1'b1, 1'b0, 1'b0);
            check1("data_oe", 1'b1, data_oe);
            check1("data", 1'b0, seen);
        end
        st(1'b0, 1'b0, 1'b0, 1'b0);
        acc_lvl = 1'b0;
        check1("data_oe", 1'b0, data_oe);
        for (int i = 0; i < 8; i++) rd(1'b1, i);
        summarize();
    end

    // Hang guard
    initial begin
        #400_000;
        fail_count++;
        summarize();
    end

endmodule : scpa_top_tb_top
